// ---- shared/hmsc_pkg.sv ----
// Constants for the halt-mode standby control block.
// Assumes a single clock domain and a plain word-wide register port.
package hmsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] HMSC_ADDR_CONF   = 4'h0;
    localparam logic [3:0] HMSC_ADDR_MASK   = 4'h4;
    localparam logic [3:0] HMSC_ADDR_STATUS = 4'h8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HMSC_CONF_ACK_EN_BIT  = 0;
    localparam int HMSC_CONF_LONG_WT_BIT = 1;
    localparam int HMSC_ST_HALT_BIT      = 0;
    localparam int HMSC_ST_WAIT_BIT      = 1;
    localparam int HMSC_ST_ENTRY_LOW_BIT = 2;
    localparam int HMSC_ST_LS_STOP_BIT   = 3;
    localparam int HMSC_ST_PEND_BIT      = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] HMSC_CONF_RESET = 2'h0;
    localparam logic       HMSC_MASK_RESET = 1'b1;

    // ------------------------------------------------------------
    // Timing counts, in CPU clocks
    // ------------------------------------------------------------
    localparam logic [3:0] HMSC_WAIT_VEC_SHORT = 4'h8;
    localparam logic [3:0] HMSC_WAIT_VEC_LONG  = 4'h9;
    localparam logic [3:0] HMSC_WAIT_RES_SHORT = 4'h2;
    localparam logic [3:0] HMSC_WAIT_RES_LONG  = 4'h3;

    // ------------------------------------------------------------
    // Count clock codes
    // ------------------------------------------------------------
    localparam logic [2:0] HMSC_TMRB_SEL_LS_DIV128 = 3'h7;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HMSC_RUN,
        HMSC_HALT,
        HMSC_WAIT
    } hmsc_state_e;

endpackage : hmsc_pkg

// ---- design/hmsc_top.sv ----
// Halt-mode standby control: CPU clock gate, latch hold, peripheral run enables, wake-up.
// Assumes the core pulses HALT_EXEC for one cycle and the selections come from REF_CLK logic.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module hmsc_top
    import hmsc_pkg::*;
#(
    parameter int NUM_INT   = 8,
    parameter int PORT_BITS = 8
) (
    // Clock, reset, enable
    input  wire logic                 REF_CLK,
    input  wire logic                 RESET,
    input  wire logic                 CLK_EN,
    // Register port
    input  wire logic [3:0]           REG_ADDR,
    input  wire logic [31:0]          REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output logic      [31:0]          REG_RDATA,
    // CPU core
    input  wire logic                 HALT_EXEC,
    input  wire logic                 CPU_ON_LOW_SPEED,
    output logic                      CPU_CLK_EN,
    output logic                      HALT_ACTIVE,
    output logic                      VECTOR_REQ,
    output logic                      RESUME_REQ,
    output logic                      RESET_VECTOR_REQ,
    output logic                      STATE_HOLD,
    // Interrupt requests
    input  wire logic [NUM_INT-1:0]   INT_REQ,
    // External reset pin, asynchronous
    input  wire logic                 EXT_RESET_PIN,
    // Oscillator option and status
    input  wire logic                 LS_OSC_UNSTOPPABLE,
    input  wire logic                 LS_OSC_SW_STOPPED,
    // Peripheral count clock selections
    input  wire logic [2:0]           TMR_B_CLK_SEL,
    input  wire logic                 TMR_A_EXT_SEL,
    input  wire logic                 UART_CLK_TMR_A,
    // Port latches
    input  wire logic [PORT_BITS-1:0] PORT_LATCH_IN,
    output logic      [PORT_BITS-1:0] PORT_LATCH_OUT,
    // Peripheral run enables
    output logic                      HS_PERIPH_RUN,
    output logic                      TMR_A_RUN,
    output logic                      TMR_B_RUN,
    output logic                      UART_RUN,
    output logic                      WDT_RUN
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    hmsc_state_e          state_r;
    hmsc_state_e          state_nxt;
    logic [1:0]           conf_r;
    logic [NUM_INT-1:0]   mask_r;
    logic [31:0]          rdata_r;
    logic [3:0]           wait_cnt_r;
    logic [3:0]           wait_cnt_nxt;
    logic                 entry_low_r;
    logic                 ls_stop_r;
    logic                 vec_sel_r;
    logic                 vec_req_r;
    logic                 res_req_r;
    logic                 rst_req_r;
    logic [PORT_BITS-1:0] port_r;
    logic                 ext_rst_s1_r;
    logic                 ext_rst_s2_r;
    logic                 ext_rst_d_r;
    logic                 ext_rst_rise;
    logic                 wake;
    logic                 halted;
    logic                 low_entry_halt;
    logic                 tmr_a_ok;
    logic                 wait_done;
    logic                 entry_take;
    logic [31:0]          status_word;

    // ------------------------------------------------------------
    // External reset pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ext_rst_s1_r <= 1'b0;
            ext_rst_s2_r <= 1'b0;
            ext_rst_d_r  <= 1'b0;
        end else if (CLK_EN) begin
            ext_rst_s1_r <= EXT_RESET_PIN;
            ext_rst_s2_r <= ext_rst_s1_r;
            ext_rst_d_r  <= ext_rst_s2_r;
        end
    end

    // Edge only, so a held pin requests the vector once
    assign ext_rst_rise = ext_rst_s2_r & ~ext_rst_d_r;

    // ------------------------------------------------------------
    // Wake sources
    // ------------------------------------------------------------
    // unmasked request wakes
    assign wake = |(INT_REQ & ~mask_r);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        wait_cnt_nxt = wait_cnt_r;
        unique case (state_r)
            HMSC_RUN: begin
                if (HALT_EXEC) begin
                    state_nxt = HMSC_HALT;
                end
            end
            HMSC_HALT: begin
                if (ext_rst_rise) begin
                    state_nxt = HMSC_RUN;
                end else if (wake) begin
                    state_nxt = HMSC_WAIT;
                    if (conf_r[HMSC_CONF_ACK_EN_BIT]) begin
                        wait_cnt_nxt = conf_r[HMSC_CONF_LONG_WT_BIT] ? HMSC_WAIT_VEC_LONG
                                                                      : HMSC_WAIT_VEC_SHORT;
                    end else begin
                        wait_cnt_nxt = conf_r[HMSC_CONF_LONG_WT_BIT] ? HMSC_WAIT_RES_LONG
                                                                      : HMSC_WAIT_RES_SHORT;
                    end
                end
            end
            HMSC_WAIT: begin
                if (ext_rst_rise) begin
                    state_nxt = HMSC_RUN;
                end else if (wait_cnt_r == 4'h1) begin
                    state_nxt    = HMSC_RUN;
                    wait_cnt_nxt = 4'h0;
                end else begin
                    wait_cnt_nxt = wait_cnt_r - 4'h1;
                end
            end
            // Unused code falls back to run
            default: begin
                state_nxt    = HMSC_RUN;
                wait_cnt_nxt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_r <= HMSC_RUN;
        end else if (CLK_EN) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            wait_cnt_r <= 4'h0;
        end else if (CLK_EN) begin
            wait_cnt_r <= wait_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Entry conditions captured at the halt instruction
    // ------------------------------------------------------------
    assign entry_take = (state_r == HMSC_RUN) && HALT_EXEC;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            entry_low_r <= 1'b0;
        end else if (CLK_EN && entry_take) begin
            entry_low_r <= CPU_ON_LOW_SPEED;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ls_stop_r <= 1'b0;
        end else if (CLK_EN && entry_take) begin
            ls_stop_r <= ~LS_OSC_UNSTOPPABLE & LS_OSC_SW_STOPPED;
        end
    end

    // ------------------------------------------------------------
    // Exit pulses to the core
    // ------------------------------------------------------------
    // A reset edge in the last wait cycle wins over the wake pulse
    assign wait_done = (state_r == HMSC_WAIT) && !ext_rst_rise && (wait_cnt_r == 4'h1);

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            vec_sel_r <= 1'b0;
        end else if (CLK_EN && state_r == HMSC_HALT && wake) begin
            vec_sel_r <= conf_r[HMSC_CONF_ACK_EN_BIT];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            vec_req_r <= 1'b0;
            res_req_r <= 1'b0;
        end else if (CLK_EN) begin
            vec_req_r <= wait_done && vec_sel_r;
            res_req_r <= wait_done && !vec_sel_r;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rst_req_r <= 1'b0;
        end else if (CLK_EN) begin
            rst_req_r <= ext_rst_rise;
        end
    end

    // ------------------------------------------------------------
    // Port latch hold
    // ------------------------------------------------------------
    assign halted = (state_r != HMSC_RUN);

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            port_r <= '0;
        end else if (CLK_EN) begin
            if (!halted && !entry_take) begin
                port_r <= PORT_LATCH_IN;
            end
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            conf_r <= HMSC_CONF_RESET;
        end else if (CLK_EN && REG_WR && REG_ADDR == HMSC_ADDR_CONF) begin
            conf_r <= REG_WDATA[1:0];
        end
    end

    // Masks reset set, so nothing wakes before software opens a source
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            mask_r <= {NUM_INT{HMSC_MASK_RESET}};
        end else if (CLK_EN && REG_WR && REG_ADDR == HMSC_ADDR_MASK) begin
            mask_r <= REG_WDATA[NUM_INT-1:0];
        end
    end

    always_comb begin
        status_word                        = 32'h0;
        status_word[HMSC_ST_HALT_BIT]      = (state_r == HMSC_HALT);
        status_word[HMSC_ST_WAIT_BIT]      = (state_r == HMSC_WAIT);
        status_word[HMSC_ST_ENTRY_LOW_BIT] = entry_low_r;
        status_word[HMSC_ST_LS_STOP_BIT]   = ls_stop_r;
        status_word[HMSC_ST_PEND_BIT]      = wake;
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rdata_r <= 32'h0;
        end else if (CLK_EN) begin
            if (REG_RD) begin
                unique case (REG_ADDR)
                    HMSC_ADDR_CONF:   rdata_r <= {30'h0, conf_r};
                    HMSC_ADDR_MASK:   rdata_r <= {{(32-NUM_INT){1'b0}}, mask_r};
                    HMSC_ADDR_STATUS: rdata_r <= status_word;
                    default:          rdata_r <= 32'h0;
                endcase
            end else begin
                rdata_r <= 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Peripheral run enables
    // ------------------------------------------------------------
    assign low_entry_halt = halted & entry_low_r;

    // high-speed set only on fast entry
    assign HS_PERIPH_RUN = ~low_entry_halt;

    assign TMR_B_RUN = ~low_entry_halt | (TMR_B_CLK_SEL == HMSC_TMRB_SEL_LS_DIV128);

    assign tmr_a_ok  = ~low_entry_halt | TMR_A_EXT_SEL;
    assign TMR_A_RUN = tmr_a_ok;

    // serial port from running timer A
    assign UART_RUN = ~low_entry_halt | (UART_CLK_TMR_A & TMR_A_EXT_SEL);

    assign WDT_RUN = ~halted | LS_OSC_UNSTOPPABLE;

    // ------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------
    // CPU clock gated through halt and wait
    assign CPU_CLK_EN       = ~halted;
    assign HALT_ACTIVE      = halted;
    // core holds its state while this is high
    assign STATE_HOLD       = halted;
    assign VECTOR_REQ       = vec_req_r;
    assign RESUME_REQ       = res_req_r;
    assign RESET_VECTOR_REQ = rst_req_r;
    assign PORT_LATCH_OUT   = port_r;
    assign REG_RDATA        = rdata_r;

endmodule : hmsc_top

`default_nettype wire

// ---- tb/hmsc_core_model.sv ----
// Behavioural core and interrupt logic facing the halt control block.
// Assumes one-cycle halt commands and level interrupt commands from the bench.
`timescale 1ns/100ps
`default_nettype none
module hmsc_core_model (
    // Clock and bench commands
    input  wire logic       clk,
    input  wire logic       halt_cmd,
    input  wire logic       low_cmd,
    input  wire logic [7:0] irq_cmd,
    // Block side
    input  wire logic       cpu_clk_en,
    output logic            halt_exec,
    output logic            on_low,
    output logic      [7:0] int_req,
    output logic      [7:0] port_val
);
    // ----------------------------------------------------------------
    // Core behaviour
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        // A stopped core cannot execute the halt instruction
        halt_exec <= halt_cmd && cpu_clk_en;
        on_low    <= low_cmd;
        int_req   <= irq_cmd;
        // Port data keeps moving in halt too, harsher than a stopped core
        port_val  <= 8'($urandom);
    end
endmodule : hmsc_core_model
`default_nettype wire

// ---- tb/hmsc_properties.sv ----
// Concurrent checks on the halt control block ports.
// Assumes a single REF_CLK domain; CLK_EN low freezes block and shadow alike.
`timescale 1ns/100ps
`default_nettype none
module hmsc_checker
    import hmsc_pkg::*;
#(
    parameter int NUM_INT   = 8,
    parameter int PORT_BITS = 8
) (
    // Clock, reset, register port
    input wire logic                 REF_CLK,
    input wire logic                 RESET,
    input wire logic                 CLK_EN,
    input wire logic [3:0]           REG_ADDR,
    input wire logic [31:0]          REG_WDATA,
    input wire logic                 REG_WR,
    // Core side
    input wire logic                 HALT_EXEC,
    input wire logic                 CPU_ON_LOW_SPEED,
    input wire logic                 CPU_CLK_EN,
    input wire logic                 HALT_ACTIVE,
    input wire logic                 STATE_HOLD,
    input wire logic                 VECTOR_REQ,
    input wire logic                 RESUME_REQ,
    input wire logic                 RESET_VECTOR_REQ,
    input wire logic [NUM_INT-1:0]   INT_REQ,
    input wire logic                 EXT_RESET_PIN,
    // Options, selections, enables
    input wire logic                 LS_OSC_UNSTOPPABLE,
    input wire logic [2:0]           TMR_B_CLK_SEL,
    input wire logic                 TMR_A_EXT_SEL,
    input wire logic                 UART_CLK_TMR_A,
    input wire logic [PORT_BITS-1:0] PORT_LATCH_OUT,
    input wire logic                 HS_PERIPH_RUN,
    input wire logic                 TMR_A_RUN,
    input wire logic                 TMR_B_RUN,
    input wire logic                 UART_RUN,
    input wire logic                 WDT_RUN
);
    logic [1:0]         conf_sh;
    logic [NUM_INT-1:0] mask_sh;
    logic               low_sh;
    logic               ack_sh;
    logic [3:0]         cnt;
    wire logic          wake = HALT_ACTIVE && cnt == 4'h0 && |(INT_REQ & ~mask_sh);
    wire logic [3:0]    n_w  = conf_sh[0] ? (conf_sh[1] ? HMSC_WAIT_VEC_LONG : HMSC_WAIT_VEC_SHORT)
                                          : (conf_sh[1] ? HMSC_WAIT_RES_LONG : HMSC_WAIT_RES_SHORT);
    // Shadow of settings and exit wait; a write on the wake edge is not seen by that wake
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            conf_sh <= 2'h0;
            mask_sh <= '1;
            low_sh  <= 1'b0;
            ack_sh  <= 1'b0;
            cnt     <= 4'h0;
        end else if (CLK_EN) begin
            if (REG_WR && REG_ADDR == HMSC_ADDR_CONF) conf_sh <= REG_WDATA[1:0];
            if (REG_WR && REG_ADDR == HMSC_ADDR_MASK) mask_sh <= REG_WDATA[NUM_INT-1:0];
            if (HALT_EXEC && CPU_CLK_EN) low_sh <= CPU_ON_LOW_SPEED;
            if (wake) begin
                cnt    <= n_w;
                ack_sh <= conf_sh[0];
            end else if (!HALT_ACTIVE) cnt <= 4'h0;
            else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET || !CLK_EN);
    a_entry_only: assert property ($rose(HALT_ACTIVE) |-> $past(HALT_EXEC))
        else $error("halt entered without halt instruction");
    a_entry_any_clk: assert property (HALT_EXEC && CPU_CLK_EN |=> HALT_ACTIVE)
        else $error("halt instruction not accepted");
    a_clk_gated: assert property (CPU_CLK_EN == !HALT_ACTIVE && STATE_HOLD == HALT_ACTIVE)
        else $error("cpu clock gate or hold wrong");
    a_latch_frozen: assert property (HALT_ACTIVE |-> $stable(PORT_LATCH_OUT))
        else $error("port latch moved in halt");
    a_hs_periph: assert property (HS_PERIPH_RUN == !(HALT_ACTIVE && low_sh))
        else $error("high-speed peripheral enable wrong");
    a_timer_b_run: assert property (TMR_B_RUN == (HS_PERIPH_RUN || TMR_B_CLK_SEL == HMSC_TMRB_SEL_LS_DIV128))
        else $error("timer b enable wrong");
    a_timer_a_run: assert property (TMR_A_RUN == (HS_PERIPH_RUN || TMR_A_EXT_SEL))
        else $error("timer a enable wrong");
    a_serial_run: assert property (UART_RUN == (HS_PERIPH_RUN || (UART_CLK_TMR_A && TMR_A_EXT_SEL)))
        else $error("serial enable wrong");
    a_watchdog_run: assert property (WDT_RUN == (!HALT_ACTIVE || LS_OSC_UNSTOPPABLE))
        else $error("watchdog enable wrong");
    a_masked_hold: assert property (HALT_ACTIVE && !wake && cnt == 4'h0 && !EXT_RESET_PIN && !$past(EXT_RESET_PIN)
        && !$past(EXT_RESET_PIN, 2) && !$past(EXT_RESET_PIN, 3) |=> HALT_ACTIVE)
        else $error("halt left without a wake source");
    a_wake_result: assert property (cnt == 4'h1 && HALT_ACTIVE |=> CPU_CLK_EN
        && VECTOR_REQ == ack_sh && RESUME_REQ == !ack_sh)
        else $error("wake result or wait wrong");
    a_pulse_timing: assert property (VECTOR_REQ || RESUME_REQ |-> $past(cnt) == 4'h1)
        else $error("wake pulse at wrong time");
    a_reset_exit: assert property ($rose(EXT_RESET_PIN) |-> ##[2:6] (RESET_VECTOR_REQ
        && !HALT_ACTIVE && !VECTOR_REQ && !RESUME_REQ))
        else $error("reset pin did not end halt");
    cover property (VECTOR_REQ);
    cover property (RESUME_REQ);
    cover property (RESET_VECTOR_REQ && $past(HALT_ACTIVE));
endmodule : hmsc_checker
bind hmsc_top hmsc_checker #(.NUM_INT(NUM_INT), .PORT_BITS(PORT_BITS)) i_hmsc_checker (.REF_CLK, .RESET, .CLK_EN,
    .REG_ADDR, .REG_WDATA, .REG_WR, .HALT_EXEC, .CPU_ON_LOW_SPEED, .CPU_CLK_EN, .HALT_ACTIVE, .STATE_HOLD,
    .VECTOR_REQ, .RESUME_REQ, .RESET_VECTOR_REQ, .INT_REQ, .EXT_RESET_PIN, .LS_OSC_UNSTOPPABLE,
    .TMR_B_CLK_SEL, .TMR_A_EXT_SEL, .UART_CLK_TMR_A, .PORT_LATCH_OUT, .HS_PERIPH_RUN, .TMR_A_RUN,
    .TMR_B_RUN, .UART_RUN, .WDT_RUN);
`default_nettype wire

// ---- tb/halt_mode_standby_control_tb.sv ----
// Self-checking bench for the halt control block with a core model.
// Assumes the model and checker files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected at %0t: value mismatch", $time); end end
module halt_mode_standby_control_tb;
    import hmsc_pkg::*;
    typedef struct {logic rd; logic [31:0] val; int lo; int hi;} hmsc_exp_s;
    hmsc_exp_s   q[$];
    int          cyc = 0, n_mismatch = 0, samples_checked = 0;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, hcmd = 1'b0, lcmd = 1'b0, pin = 1'b0;
    logic        unst = 1'b0, swst = 1'b0, asel = 1'b0, usel = 1'b0, ce = 1'b1;
    logic [2:0]  bsel = 3'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [7:0]  irq = 8'h00;
    wire  [31:0] rdata;
    wire  [7:0]  ireq, pin_in, pout;
    wire         hexec, onlow, cpuen, hact, vec, res, rvec, hold, hs, ta, tbr, ua, wdt;
    hmsc_top i_hmsc_top (.REF_CLK(clk), .RESET(rst), .CLK_EN(ce), .REG_ADDR(addr), .REG_WDATA(wdat),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .HALT_EXEC(hexec), .CPU_ON_LOW_SPEED(onlow),
        .CPU_CLK_EN(cpuen), .HALT_ACTIVE(hact), .VECTOR_REQ(vec), .RESUME_REQ(res), .RESET_VECTOR_REQ(rvec),
        .STATE_HOLD(hold), .INT_REQ(ireq), .EXT_RESET_PIN(pin), .LS_OSC_UNSTOPPABLE(unst),
        .LS_OSC_SW_STOPPED(swst), .TMR_B_CLK_SEL(bsel), .TMR_A_EXT_SEL(asel), .UART_CLK_TMR_A(usel),
        .PORT_LATCH_IN(pin_in), .PORT_LATCH_OUT(pout), .HS_PERIPH_RUN(hs), .TMR_A_RUN(ta), .TMR_B_RUN(tbr),
        .UART_RUN(ua), .WDT_RUN(wdt));
    hmsc_core_model i_hmsc_core_model (.clk(clk), .halt_cmd(hcmd), .low_cmd(lcmd), .irq_cmd(irq),
        .cpu_clk_en(cpuen), .halt_exec(hexec), .on_low(onlow), .int_req(ireq), .port_val(pin_in));
    initial forever #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // ----------------------------------------------------------------
    // Bus tasks and result monitor
    // ----------------------------------------------------------------
    task automatic wrr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    task automatic rdr(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        q.push_back('{1'b1, e, cyc + 2, cyc + 2});
        @(posedge clk);
        rd <= 1'b0;
    endtask : rdr
    task automatic halt(input logic lo);
        @(posedge clk);
        hcmd <= 1'b1;
        lcmd <= lo;
        @(posedge clk);
        hcmd <= 1'b0;
        for (int i = 0; i < 8 && hact !== 1'b1; i++) @(posedge clk);
        `CHK(hact, 1'b1)
    endtask : halt
    task automatic drain();
        for (int i = 0; i < 40 && q.size() != 0; i++) @(posedge clk);
    endtask : drain
    task automatic tally_and_finish();
        if (q.size() != 0) n_mismatch++;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // Sampled mid-cycle so the edge updates have landed
    always @(negedge clk) begin
        if (!rst && q.size() != 0 && q[0].rd && cyc == q[0].lo) begin
            `CHK(rdata, q[0].val)
            void'(q.pop_front());
        end
        if (!rst && (vec | res | rvec) !== 1'b0) begin
            if (q.size() == 0 || q[0].rd) begin
                n_mismatch++;
                $display("unexpected at %0t: stray wake pulse", $time);
            end else begin
                `CHK({rvec, res, vec}, q[0].val[2:0])
                `CHK(cyc >= q[0].lo && cyc <= q[0].hi, 1'b1)
                void'(q.pop_front());
            end
        end
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        $display("unexpected at %0t: timeout", $time);
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        int m, b, n;
        void'($urandom(90));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdr(HMSC_ADDR_CONF, 32'h0);
        rdr(HMSC_ADDR_MASK, 32'hFF);
        wrr(HMSC_ADDR_STATUS, 32'hFFFFFFFF);
        rdr(HMSC_ADDR_STATUS, 32'h0);
        rdr(4'hC, 32'h0);
        drain();
        $display("test registers done");
        // Every acknowledge and wait setting, high- and low-speed entry
        for (m = 0; m < 4; m++) begin
            b = $urandom_range(7);
            @(posedge clk);
            bsel <= (m == 3) ? HMSC_TMRB_SEL_LS_DIV128 : 3'($urandom);
            {unst, swst, asel, usel} <= 4'($urandom);
            wrr(HMSC_ADDR_CONF, 32'(m));
            wrr(HMSC_ADDR_MASK, ~(32'h1 << b));
            halt(m[1]);
            rdr(HMSC_ADDR_STATUS, {28'h0, !unst && swst, m[1], 2'b01});
            `CHK(hs, !m[1])
            `CHK(tbr, !m[1] || bsel == HMSC_TMRB_SEL_LS_DIV128)
            `CHK(ta, !m[1] || asel)
            `CHK(ua, !m[1] || (usel && asel))
            `CHK(wdt, unst)
            `CHK(cpuen, 1'b0)
            irq <= ~(8'h1 << b);
            repeat (10) @(posedge clk);
            `CHK(hact, 1'b1)
            n = m[0] ? (m[1] ? 9 : 8) : (m[1] ? 3 : 2);
            // Four frozen edges hold off the wake, which would have come on the second
            q.push_back('{1'b0, m[0] ? 32'h1 : 32'h2, cyc + n + 6, cyc + n + 6});
            irq <= 8'hFF;
            ce  <= 1'b0;
            repeat (4) @(posedge clk);
            ce <= 1'b1;
            drain();
            irq <= 8'h00;
        end
        $display("test wake done");
        // Reset pin while running, then while halted
        for (m = 0; m < 2; m++) begin
            if (m == 1) halt(1'b0);
            @(posedge clk);
            pin <= 1'b1;
            q.push_back('{1'b0, 32'h4, cyc + 4, cyc + 6});
            repeat (8) @(posedge clk);
            pin <= 1'b0;
            `CHK(hact, 1'b0)
            drain();
        end
        $display("test reset pin done");
        tally_and_finish();
    end
endmodule : halt_mode_standby_control_tb
`default_nettype wire
